// [include/rimb_pkg.sv]
// constants and types for the regulator interrupt mask bank
package rimb_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_TOP_MASK_FIRST   = 8'h21;
  localparam logic [7:0] OFS_TOP_MASK_SECOND  = 8'h22;
  localparam logic [7:0] OFS_PHASE01_MASK     = 8'h23;
  localparam logic [7:0] OFS_TOP_FLAGS_FIRST  = 8'h18;
  localparam logic [7:0] OFS_TOP_FLAGS_SECOND = 8'h19;
  localparam logic [7:0] OFS_PHASE01_FLAGS    = 8'h1A;
  localparam logic [7:0] OFS_TOP_LIVE         = 8'h1E;
  localparam logic [7:0] OFS_PHASE01_LIVE     = 8'h1F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_SYNC_CLK     = 4;
  localparam int unsigned BIT_THERMAL_WARN = 2;
  localparam int unsigned BIT_LOAD_READY   = 0;
  localparam int unsigned BIT_REG_RESET    = 0;
  localparam int unsigned BIT_PH1_GOOD     = 6;
  localparam int unsigned BIT_PH1_LIMIT    = 4;
  localparam int unsigned BIT_PH0_GOOD     = 2;
  localparam int unsigned BIT_PH0_LIMIT    = 0;

  // ---------------------------------------------------------------
  // writable bits, reset values and implemented flag bits
  // ---------------------------------------------------------------
  localparam logic [7:0] WMASK_TOP_FIRST   = 8'hFF;
  localparam logic [7:0] WMASK_TOP_SECOND  = 8'hFF;
  localparam logic [7:0] WMASK_PHASE01     = 8'hDD;
  localparam logic [7:0] RST_TOP_FIRST     = 8'h80;
  localparam logic [7:0] RST_TOP_SECOND    = 8'h00;
  localparam logic [7:0] RST_PHASE01       = 8'h00;
  localparam logic [7:0] FLAGS_TOP_FIRST   = 8'h15;
  localparam logic [7:0] FLAGS_TOP_SECOND  = 8'h01;
  localparam logic [7:0] FLAGS_PHASE01     = 8'h55;

  // register port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rimb_req_t;

  // raw event sources
  typedef struct packed {
    logic sync_clk_lost;
    logic thermal_warn;
    logic load_ready;
    logic reg_reset;
    logic ph0_good;
    logic ph0_limit;
    logic ph1_good;
    logic ph1_limit;
  } rimb_src_t;

endpackage

// [logic/rimb_flag.sv]
// one sticky interrupt flag with mask gating and write-one-to-clear
module rimb_flag (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic event_i,
  input  wire logic mask_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic next_flag;

  // a masked event never sets the flag; set wins over clear
  always_comb begin
    next_flag = flag_o;
    if (clear_i) begin
      next_flag = 1'b0;
    end
    if (event_i && !mask_i) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule

// [logic/rimb_top.sv]
// mask registers, event flags and interrupt output for phases 0 and 1
// Functional notes
// - bit 4 first mask gates sync clock
// - bit 2 first mask gates thermal warning
// - thermal mask leaves live thermal status alone
// - bit 0 first mask gates load ready
// - 0x22 bit 0 gates register reset
// - 0x23 bit 6 gates phase 1 good
// - 0x23 bit 4 gates phase 1 limit
// - 0x23 bit 2 gates phase 0 good
// - 0x23 bit 0 gates phase 0 limit
// - good masks leave raw good status alone
// - limit masks leave raw limit status alone
// - raw good status unlatched, separate from flag
module rimb_top (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire rimb_pkg::rimb_req_t req_i,
  input  wire rimb_pkg::rimb_src_t live_i,
  input  wire rimb_pkg::rimb_src_t event_i,
  output logic [7:0]               rdata_o,
  output logic                     rvalid_o,
  output logic                     irq_o
);

  localparam int unsigned NSRC = 8;

  // ---------------------------------------------------------------
  // mask registers
  // ---------------------------------------------------------------
  logic [7:0] top_mask_first;
  logic [7:0] top_mask_second;
  logic [7:0] phase01_event_mask;

  function automatic logic hit(input rimb_pkg::rimb_req_t r,
                               input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      top_mask_first <= rimb_pkg::RST_TOP_FIRST;
    end else if (hit(req_i, rimb_pkg::OFS_TOP_MASK_FIRST)) begin
      top_mask_first <= merge(top_mask_first, req_i.wdata,
                              rimb_pkg::WMASK_TOP_FIRST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      top_mask_second <= rimb_pkg::RST_TOP_SECOND;
    end else if (hit(req_i, rimb_pkg::OFS_TOP_MASK_SECOND)) begin
      top_mask_second <= merge(top_mask_second, req_i.wdata,
                               rimb_pkg::WMASK_TOP_SECOND);
    end
  end

  // reserved bits 5 and 1 are read-only zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase01_event_mask <= rimb_pkg::RST_PHASE01;
    end else if (hit(req_i, rimb_pkg::OFS_PHASE01_MASK)) begin
      phase01_event_mask <= merge(phase01_event_mask, req_i.wdata,
                                  rimb_pkg::WMASK_PHASE01);
    end
  end

  // ---------------------------------------------------------------
  // per-source gates
  // ---------------------------------------------------------------
  logic thermal_warn_irq_gate;
  logic phase0_good_irq_gate;
  logic phase1_good_irq_gate;
  logic phase0_limit_irq_gate;
  logic phase1_limit_irq_gate;
  logic sync_gate;
  logic load_gate;
  logic reset_gate;

  assign sync_gate             = top_mask_first[rimb_pkg::BIT_SYNC_CLK];
  assign thermal_warn_irq_gate =
    top_mask_first[rimb_pkg::BIT_THERMAL_WARN];
  assign load_gate             =
    top_mask_first[rimb_pkg::BIT_LOAD_READY];
  assign reset_gate            =
    top_mask_second[rimb_pkg::BIT_REG_RESET];
  assign phase1_good_irq_gate  =
    phase01_event_mask[rimb_pkg::BIT_PH1_GOOD];
  assign phase1_limit_irq_gate =
    phase01_event_mask[rimb_pkg::BIT_PH1_LIMIT];
  assign phase0_good_irq_gate  =
    phase01_event_mask[rimb_pkg::BIT_PH0_GOOD];
  assign phase0_limit_irq_gate =
    phase01_event_mask[rimb_pkg::BIT_PH0_LIMIT];

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  logic [NSRC-1:0] ev_vec;
  logic [NSRC-1:0] gate_vec;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] flag_vec;

  // order: sync, thermal, load, reset, ph0 good, ph0 lim, ph1 good, ph1 lim
  assign ev_vec   = event_i;
  assign gate_vec = {sync_gate, thermal_warn_irq_gate, load_gate,
                     reset_gate, phase0_good_irq_gate,
                     phase0_limit_irq_gate, phase1_good_irq_gate,
                     phase1_limit_irq_gate};

  logic wr_tf1;
  logic wr_tf2;
  logic wr_pf;

  assign wr_tf1 = hit(req_i, rimb_pkg::OFS_TOP_FLAGS_FIRST);
  assign wr_tf2 = hit(req_i, rimb_pkg::OFS_TOP_FLAGS_SECOND);
  assign wr_pf  = hit(req_i, rimb_pkg::OFS_PHASE01_FLAGS);

  // write one to clear
  assign clr_vec = {
    wr_tf1 & req_i.wdata[rimb_pkg::BIT_SYNC_CLK],
    wr_tf1 & req_i.wdata[rimb_pkg::BIT_THERMAL_WARN],
    wr_tf1 & req_i.wdata[rimb_pkg::BIT_LOAD_READY],
    wr_tf2 & req_i.wdata[rimb_pkg::BIT_REG_RESET],
    wr_pf  & req_i.wdata[rimb_pkg::BIT_PH0_GOOD],
    wr_pf  & req_i.wdata[rimb_pkg::BIT_PH0_LIMIT],
    wr_pf  & req_i.wdata[rimb_pkg::BIT_PH1_GOOD],
    wr_pf  & req_i.wdata[rimb_pkg::BIT_PH1_LIMIT]};

  for (genvar g = 0; g < NSRC; g++) begin : g_flag
    rimb_flag u_flag (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .event_i (ev_vec[g]),
      .mask_i  (gate_vec[g]),
      .clear_i (clr_vec[g]),
      .flag_o  (flag_vec[g])
    );
  end

  rimb_pkg::rimb_src_t flags;
  assign flags = flag_vec;

  logic thermal_warn_flag;
  logic phase0_good_flag;
  logic phase1_good_flag;
  logic phase0_limit_flag;
  logic phase1_limit_flag;

  assign thermal_warn_flag = flags.thermal_warn;
  assign phase0_good_flag  = flags.ph0_good;
  assign phase1_good_flag  = flags.ph1_good;
  assign phase0_limit_flag = flags.ph0_limit;
  assign phase1_limit_flag = flags.ph1_limit;

  // ---------------------------------------------------------------
  // read data and interrupt
  // ---------------------------------------------------------------
  logic [7:0] top_flags_first;
  logic [7:0] top_flags_second;
  logic [7:0] phase01_flags;
  logic [7:0] top_live;
  logic [7:0] phase01_live;
  logic [7:0] next_rdata;

  always_comb begin
    top_flags_first = 8'h00;
    top_flags_first[rimb_pkg::BIT_SYNC_CLK]     = flags.sync_clk_lost;
    top_flags_first[rimb_pkg::BIT_THERMAL_WARN] = thermal_warn_flag;
    top_flags_first[rimb_pkg::BIT_LOAD_READY]   = flags.load_ready;
    top_flags_second = 8'h00;
    top_flags_second[rimb_pkg::BIT_REG_RESET]   = flags.reg_reset;
    phase01_flags = 8'h00;
    phase01_flags[rimb_pkg::BIT_PH1_GOOD]  = phase1_good_flag;
    phase01_flags[rimb_pkg::BIT_PH1_LIMIT] = phase1_limit_flag;
    phase01_flags[rimb_pkg::BIT_PH0_GOOD]  = phase0_good_flag;
    phase01_flags[rimb_pkg::BIT_PH0_LIMIT] = phase0_limit_flag;
    // live status bypasses masks and flags entirely
    top_live = 8'h00;
    top_live[rimb_pkg::BIT_SYNC_CLK]     = live_i.sync_clk_lost;
    top_live[rimb_pkg::BIT_THERMAL_WARN] = live_i.thermal_warn;
    phase01_live = 8'h00;
    phase01_live[rimb_pkg::BIT_PH1_GOOD]  = live_i.ph1_good;
    phase01_live[rimb_pkg::BIT_PH0_GOOD]  = live_i.ph0_good;
    phase01_live[rimb_pkg::BIT_PH1_LIMIT] = live_i.ph1_limit;
    phase01_live[rimb_pkg::BIT_PH0_LIMIT] = live_i.ph0_limit;
  end

  always_comb begin
    case (req_i.addr)
      rimb_pkg::OFS_TOP_MASK_FIRST:   next_rdata = top_mask_first;
      rimb_pkg::OFS_TOP_MASK_SECOND:  next_rdata = top_mask_second;
      rimb_pkg::OFS_PHASE01_MASK:     next_rdata = phase01_event_mask;
      rimb_pkg::OFS_TOP_FLAGS_FIRST:  next_rdata = top_flags_first;
      rimb_pkg::OFS_TOP_FLAGS_SECOND: next_rdata = top_flags_second;
      rimb_pkg::OFS_PHASE01_FLAGS:    next_rdata = phase01_flags;
      rimb_pkg::OFS_TOP_LIVE:         next_rdata = top_live;
      rimb_pkg::OFS_PHASE01_LIVE:     next_rdata = phase01_live;
      default:                        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |flag_vec;
    end
  end

endmodule

// [sim/rimb_top_chk.sv]
// assertion checker for the mask bank register port and interrupt
module rimb_top_chk (
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire rimb_pkg::rimb_req_t req_i,
  input wire rimb_pkg::rimb_src_t live_i,
  input wire rimb_pkg::rimb_src_t event_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                rvalid_o,
  input wire logic                irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ph_mask;

  // shadow of the writable phase 0/1 gate bits
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ph_mask <= 8'h00;
    end else if (req_i.wr && req_i.addr == 8'h23) begin
      ph_mask <= req_i.wdata & 8'hDD;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_read_answers: assert property (req_i.rd |=> rvalid_o)
    else $error("read got no valid pulse");
  a_valid_only_read: assert property (!req_i.rd |=> !rvalid_o)
    else $error("valid pulse without read");
  a_rdata_holds: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without read");
  a_irq_has_cause: assert property
    ($rose(irq_o) |-> $past(event_i, 2) != '0)
    else $error("interrupt rose without an event");
  a_ph0_good_gate: assert property
    (event_i.ph0_good && !ph_mask[2] |-> ##2 irq_o)
    else $error("open phase 0 good event gave no interrupt");
  a_ph1_limit_gate: assert property
    (event_i.ph1_limit && !ph_mask[4] |-> ##2 irq_o)
    else $error("open phase 1 limit event gave no interrupt");
  a_phase_live_raw: assert property
    (req_i.rd && req_i.addr == 8'h1F |=>
    (rdata_o & 8'h55) == {1'b0, $past(live_i.ph1_good), 1'b0,
    $past(live_i.ph1_limit), 1'b0, $past(live_i.ph0_good), 1'b0,
    $past(live_i.ph0_limit)})
    else $error("phase live status not raw");
  a_top_live_raw: assert property
    (req_i.rd && req_i.addr == 8'h1E |=>
    (rdata_o & 8'h14) == {3'b000, $past(live_i.sync_clk_lost), 1'b0,
    $past(live_i.thermal_warn), 2'b00})
    else $error("thermal live status not raw");
  a_ro_bits_clear: assert property
    (req_i.rd && req_i.addr == 8'h23 |=> (rdata_o & 8'h22) == 8'h00)
    else $error("read-only gate bits not zero");
  a_mask2_readback: assert property
    (req_i.wr && req_i.addr == 8'h22 ##1
    !req_i.wr ##1 req_i.rd && req_i.addr == 8'h22 |=>
    rdata_o == $past(req_i.wdata, 3))
    else $error("second mask read back wrong");

  c_gate_read: cover property (req_i.rd && req_i.addr == 8'h23);
  c_irq_rise: cover property ($rose(irq_o));
  c_masked_event: cover property (event_i.ph0_good && ph_mask[2]);
endmodule

bind rimb_top rimb_top_chk u_chk (
  .clk_i    (clk_i),
  .reset_i  (reset_i),
  .req_i    (req_i),
  .live_i   (live_i),
  .event_i  (event_i),
  .rdata_o  (rdata_o),
  .rvalid_o (rvalid_o),
  .irq_o    (irq_o)
);

// [sim/test_rimb_top.sv]
// self-checking bench for the regulator interrupt mask bank
module test_rimb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i;
  logic                reset_i;
  rimb_pkg::rimb_req_t req_i;
  rimb_pkg::rimb_src_t live_i;
  rimb_pkg::rimb_src_t event_i;
  logic [7:0]          rdata_o;
  logic                rvalid_o;
  logic                irq_o;
  int                  n_errors;
  int                  compares;
  // gate offset, flag offset and bit per source, event_i msb first
  localparam logic [7:0] MASK_OFS [8] = '{8'h21, 8'h21, 8'h21, 8'h22,
                                          8'h23, 8'h23, 8'h23, 8'h23};
  localparam logic [7:0] FLAG_OFS [8] = '{8'h18, 8'h18, 8'h18, 8'h19,
                                          8'h1A, 8'h1A, 8'h1A, 8'h1A};
  localparam int         FBIT [8]     = '{4, 2, 0, 0, 2, 0, 6, 4};

  rimb_top u_dut (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .req_i    (req_i),
    .live_i   (live_i),
    .event_i  (event_i),
    .rdata_o  (rdata_o),
    .rvalid_o (rvalid_o),
    .irq_o    (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i) #1;
    req_i.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clk_i) #1;
    req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i) #1;
    req_i.rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid_o});
    chk(nm, e, rdata_o);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i) #1;
    event_i = rimb_pkg::rimb_src_t'(8'h01 << b);
    @(posedge clk_i) #1;
    event_i = '0;
  endtask

  task automatic t_regs();
    reg_rd(8'h21, 8'h80, "mask1 reset");
    reg_rd(8'h22, 8'h00, "mask2 reset");
    reg_rd(8'h23, 8'h00, "mask01 reset");
    reg_wr(8'h23, 8'hFF);
    reg_rd(8'h23, 8'hDD, "mask01 ro");
    reg_wr(8'h22, 8'hFF);
    reg_rd(8'h22, 8'hFF, "mask2 rw");
    reg_wr(8'h21, 8'h15);
    reg_rd(8'h21, 8'h15, "mask1 rw");
    reg_wr(8'h30, 8'hFF);
    reg_rd(8'h30, 8'h00, "unmapped");
  endtask

  // live status must follow its inputs with every gate closed
  task automatic t_live(input logic [7:0] p);
    logic [7:0] e1;
    logic [7:0] e2;
    @(posedge clk_i) #1;
    live_i = rimb_pkg::rimb_src_t'(p);
    e1 = {3'b000, live_i.sync_clk_lost, 1'b0, live_i.thermal_warn, 2'b00};
    e2 = {1'b0, live_i.ph1_good, 1'b0, live_i.ph1_limit,
          1'b0, live_i.ph0_good, 1'b0, live_i.ph0_limit};
    reg_rd(8'h1E, e1, "top live");
    reg_rd(8'h1F, e2, "phase live");
  endtask

  task automatic t_gate(input int k);
    logic [7:0] b;
    b = 8'h01 << FBIT[k];
    reg_wr(MASK_OFS[k], b);
    pulse(7 - k);
    @(posedge clk_i) #1;
    chk("irq masked", 8'h00, {7'h00, irq_o});
    reg_rd(FLAG_OFS[k], 8'h00, "flag masked");
    reg_wr(MASK_OFS[k], 8'h00);
    reg_rd(FLAG_OFS[k], 8'h00, "flag late");
    pulse(7 - k);
    @(posedge clk_i) #1;
    chk("irq open", 8'h01, {7'h00, irq_o});
    reg_rd(FLAG_OFS[k], b, "flag open");
    reg_wr(FLAG_OFS[k], b);
    @(posedge clk_i) #1;
    chk("irq cleared", 8'h00, {7'h00, irq_o});
  endtask

  // event beside its own clear sets the flag; a late mask keeps it;
  // a reset in mid-run drops flags and interrupt and reloads the 0x21 and 0x23 mask reset values
  task automatic t_race();
    @(posedge clk_i) #1;
    event_i.ph0_good = 1'b1;
    req_i = '{wr: 1'b1, rd: 1'b0, addr: 8'h1A, wdata: 8'h04};
    @(posedge clk_i) #1;
    event_i = '0;
    req_i.wr = 1'b0;
    reg_rd(8'h1A, 8'h04, "set beats clear");
    reg_wr(8'h23, 8'h04);
    reg_rd(8'h1A, 8'h04, "flag after mask");
    chk("irq after mask", 8'h01, {7'h00, irq_o});
    @(posedge clk_i) #1;
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk("irq after reset", 8'h00, {7'h00, irq_o});
    reg_rd(8'h1A, 8'h00, "flag after reset");
    reg_rd(8'h23, 8'h00, "mask01 after reset");
    reg_rd(8'h21, 8'h80, "mask1 after reset");
  endtask

  task automatic final_report();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #25000;
    n_errors++;
    final_report();
  end

  initial begin
    reset_i = 1'b1;
    req_i = '0;
    live_i = '0;
    event_i = '0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk_i);
    #1 reset_i = 1'b0;
    t_regs();
    t_live(8'hA5);
    t_live(8'h5A);
    for (int k = 0; k < 8; k++) begin
      t_gate(k);
    end
    t_race();
    final_report();
  end
endmodule
